// >>> design/tsw_pkg.sv
// constants of the time slot switch control block
// shared by the switch control logic and its bench
package tsw_pkg;

	// ----------------------------------------
	// processor address map
	// ----------------------------------------
	localparam int CTRL_SEL_BIT = 5;
	localparam int CH_ADDR_W    = 5;

	// ----------------------------------------
	// switch_control fields
	// ----------------------------------------
	localparam int SM_BIT  = 7;
	localparam int PE_BIT  = 6;
	localparam int MS_HI   = 4;
	localparam int MS_LO   = 3;
	localparam int STA_HI  = 1;
	localparam int STA_LO  = 0;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] CTRL_MASK = 8'hdb;

	localparam logic [1:0] MS_DATA = 2'h1;
	localparam logic [1:0] MS_LOW  = 2'h2;
	localparam logic [1:0] MS_HIGH = 2'h3;

	// ----------------------------------------
	// channel_control_high / channel_source_low
	// ----------------------------------------
	localparam int CS_BIT     = 2;
	localparam int OE_BIT     = 0;
	localparam int SRC_STR_HI = 6;
	localparam int SRC_STR_LO = 5;
	localparam int SRC_CH_HI  = 4;
	localparam int SRC_CH_LO  = 0;

	// ----------------------------------------
	// serial framing
	// ----------------------------------------
	localparam int SER_CLK_KHZ   = 4096;
	localparam int FRAME_KHZ     = 8;
	localparam int EDGES_PER_FRM = SER_CLK_KHZ / FRAME_KHZ;
	localparam int STREAMS       = 4;
	localparam int CH_PER_STREAM = 32;
	localparam int FIFO_DEPTH    = 8;

endpackage

// >>> design/tsw_switch_ctrl.sv
// switch control register, connection memories, data memory and
// the serial framing that uses them; holds its own small fifo
// assumes pins arrive asynchronously to core_clk_i
//
// Contract
// - per-channel control memory is not cleared; it holds garbage until written.
// - split bit set: reads from data memory, writes to low memory.
// - split bit clear: memory-select field picks the memory accessed.
// - stream-select field picks the stream subsection for later accesses.
// - select 01 data (read only), 10 low, 11 high, 00 unused.
// - global processor mode sends every low byte unless output-drive low.
// - global mode clear: each channel follows its own control bits.
// - channel-source bit set: low byte is transmitted verbatim.
// - channel-source bit clear: low byte addresses data memory for output.
// - with drive high and mode clear, enable bit drives or tristates.
// - high memory bits 7 to 3 read as zero.
// - low bits 6-5 give source stream, bit 6 most significant.
// - low bits 4-0 give source channel 0 to 31.
// - address bit 5 low reaches control, high selects one of 32 channels.
// - output-drive low forces every serial output to high impedance.
// - each output byte is fetched during the preceding channel slot.

// ----------------------------------------
// fifo between receive framing and data memory
// ----------------------------------------
module tsw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem[rp_r];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module tsw_switch_ctrl
	import tsw_pkg::*;
#(
	parameter int NSTR = STREAMS
) (
	// clock and reset
	input  wire logic            core_clk_i,
	input  wire logic            rst_n_i,
	// serial side
	input  wire logic            ser_clk_i,
	input  wire logic            frame_n_i,
	input  wire logic [NSTR-1:0] rx_i,
	input  wire logic            ode_i,
	output logic      [NSTR-1:0] tx_o,
	output logic      [NSTR-1:0] tx_oe_o,
	// processor port
	input  wire logic            cs_n_i,
	input  wire logic            rd_i,
	input  wire logic [5:0]      addr_i,
	input  wire logic [7:0]      data_i,
	output logic      [7:0]      data_o,
	output logic                 data_oe_o,
	output logic                 ack_n_o,
	output logic                 ack_oe_o
);
	localparam int PW  = 19 + NSTR;
	localparam int FW  = CH_ADDR_W + 8 * NSTR;
	localparam int MIW = 2 + CH_ADDR_W;

	typedef enum logic {BUS_IDLE, BUS_HOLD} tsw_bus_t;

	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	logic          rst_q1_r;
	logic          rst_q2_r;
	logic          rst_n;
	logic [PW-1:0] pin_q1_r;
	logic [PW-1:0] pin_q2_r;
	logic [PW-1:0] pin_raw;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1_r <= 1'b0;
			rst_q2_r <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rst_q2_r <= rst_q1_r;
		end
	end
	assign rst_n = rst_q2_r;

	// cs and frame inverted so an idle pin syncs as zero
	assign pin_raw = {ser_clk_i, ~frame_n_i, ode_i, ~cs_n_i,
		rd_i, addr_i, data_i, rx_i};

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_q1_r <= '0;
			pin_q2_r <= '0;
		end else begin
			pin_q1_r <= pin_raw;
			pin_q2_r <= pin_q1_r;
		end
	end

	logic            ser_clk_s;
	logic            frame_s;
	logic            ode_s;
	logic            cs_s;
	logic            rd_s;
	logic [5:0]      addr_s;
	logic [7:0]      din_s;
	logic [NSTR-1:0] rx_s;

	assign {ser_clk_s, frame_s, ode_s, cs_s, rd_s,
		addr_s, din_s, rx_s} = pin_q2_r;

	// ----------------------------------------
	// memories, never cleared
	// ----------------------------------------
	logic [7:0] dm_mem  [NSTR*CH_PER_STREAM];
	logic [7:0] cml_mem [NSTR*CH_PER_STREAM];
	logic [1:0] cmh_mem [NSTR*CH_PER_STREAM];

	// ----------------------------------------
	// switch_control register
	// ----------------------------------------
	logic [7:0] ctrl_r;
	logic       sm;
	logic       pe;
	logic [1:0] ms;
	logic [1:0] sta;

	assign sm  = ctrl_r[SM_BIT];
	assign pe  = ctrl_r[PE_BIT];
	assign ms  = ctrl_r[MS_HI:MS_LO];
	assign sta = ctrl_r[STA_HI:STA_LO];

	// ----------------------------------------
	// processor access decode
	// ----------------------------------------
	tsw_bus_t       bus_r;
	logic           acc_go;
	logic           is_ctrl;
	logic [MIW-1:0] m_idx;
	logic           wr_cml;
	logic           wr_cmh;
	logic           rd_dm;
	logic [7:0]     rd_val;

	assign acc_go  = (bus_r == BUS_IDLE) & cs_s;
	assign is_ctrl = ~addr_s[CTRL_SEL_BIT];
	assign m_idx   = {sta, addr_s[CH_ADDR_W-1:0]};
	// split: writes to low memory, reads from data memory
	assign wr_cml  = acc_go & ~rd_s & ~is_ctrl
		& (sm | ms == MS_LOW);
	assign wr_cmh  = acc_go & ~rd_s & ~is_ctrl
		& ~sm & (ms == MS_HIGH);
	// data memory and code 00 get no write path
	assign rd_dm   = acc_go & rd_s & ~is_ctrl
		& (sm | ms == MS_DATA);

	always_comb begin
		rd_val = 8'h00;
		if (is_ctrl) begin
			rd_val = ctrl_r;
		end else if (sm || ms == MS_DATA) begin
			rd_val = dm_mem[m_idx];
		end else if (ms == MS_LOW) begin
			rd_val = cml_mem[m_idx];
		end else if (ms == MS_HIGH) begin
			// upper bits have no storage
			rd_val = 8'h00;
			rd_val[CS_BIT] = cmh_mem[m_idx][1];
			rd_val[OE_BIT] = cmh_mem[m_idx][0];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
		end else if (acc_go && !rd_s && is_ctrl) begin
			ctrl_r <= din_s & CTRL_MASK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (wr_cml) begin
			cml_mem[m_idx] <= din_s;
		end
		if (wr_cmh) begin
			cmh_mem[m_idx] <= {din_s[CS_BIT], din_s[OE_BIT]};
		end
	end

	// ----------------------------------------
	// processor handshake
	// ----------------------------------------
	logic [7:0] dout_r;
	logic       dout_oe_r;
	logic       ack_oe_r;
	logic       ack_n_r;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bus_r     <= BUS_IDLE;
			dout_r    <= 8'h00;
			dout_oe_r <= 1'b0;
			ack_oe_r  <= 1'b0;
			ack_n_r   <= 1'b1;
		end else begin
			case (bus_r)
				BUS_IDLE: begin
					if (cs_s) begin
						bus_r     <= BUS_HOLD;
						dout_r    <= rd_val;
						dout_oe_r <= rd_s;
						ack_oe_r  <= 1'b1;
						ack_n_r   <= 1'b0;
					end
				end
				BUS_HOLD: begin
					if (!cs_s) begin
						bus_r     <= BUS_IDLE;
						dout_oe_r <= 1'b0;
						ack_oe_r  <= 1'b0;
						ack_n_r   <= 1'b1;
					end
				end
				default: begin
					bus_r <= BUS_IDLE;
				end
			endcase
		end
	end

	assign data_o    = dout_r;
	assign data_oe_o = dout_oe_r;
	assign ack_oe_o  = ack_oe_r;
	assign ack_n_o   = ack_n_r;

	// ----------------------------------------
	// serial timing: two edges per bit
	// ----------------------------------------
	logic       ser_clk_d_r;
	logic       ser_rise;
	logic [8:0] cnt_r;
	logic [4:0] ch;
	logic [4:0] ch_nxt;
	logic       ch_end;

	assign ser_rise = ser_clk_s & ~ser_clk_d_r;
	assign ch       = cnt_r[8:4];
	assign ch_nxt   = ch + 5'h01;
	assign ch_end   = ser_rise & (cnt_r[3:0] == 4'hf);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ser_clk_d_r <= 1'b0;
			cnt_r       <= '0;
		end else begin
			ser_clk_d_r <= ser_clk_s;
			if (ser_rise) begin
				cnt_r <= frame_s ? 9'h000 : cnt_r + 9'h001;
			end
		end
	end

	// ----------------------------------------
	// receive: bytes go through the fifo
	// ----------------------------------------
	logic [7:0]      rx_sh_r [NSTR];
	logic            pend_v_r;
	logic [FW-1:0]   pend_d_r;
	logic            pend_rdy;
	logic            drn_v;
	logic [FW-1:0]   drn_d;
	logic [8*NSTR-1:0] rx_full;

	always_comb begin
		for (int s = 0; s < NSTR; s++) begin
			rx_full[8*s +: 8] = {rx_sh_r[s][6:0], rx_s[s]};
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < NSTR; s++) begin
				rx_sh_r[s] <= 8'h00;
			end
		end else if (ser_rise && cnt_r[0]) begin
			for (int s = 0; s < NSTR; s++) begin
				rx_sh_r[s] <= {rx_sh_r[s][6:0], rx_s[s]};
			end
		end
	end

	// pending byte group waits while the fifo is full
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pend_v_r <= 1'b0;
			pend_d_r <= '0;
		end else if (ch_end) begin
			pend_v_r <= 1'b1;
			pend_d_r <= {ch, rx_full};
		end else if (pend_rdy) begin
			pend_v_r <= 1'b0;
		end
	end

	tsw_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (core_clk_i),
		.rst_n_i     (rst_n),
		.in_valid_i  (pend_v_r),
		.in_ready_o  (pend_rdy),
		.in_data_i   (pend_d_r),
		.out_valid_o (drn_v),
		.out_ready_i (~rd_dm),
		.out_data_o  (drn_d)
	);

	// drain stalls while the processor reads data memory
	always_ff @(posedge core_clk_i) begin
		if (drn_v && !rd_dm) begin
			for (int s = 0; s < NSTR; s++) begin
				dm_mem[{2'(s), drn_d[FW-1 -: CH_ADDR_W]}]
					<= drn_d[8*s +: 8];
			end
		end
	end

	// ----------------------------------------
	// transmit: fetch next channel a slot early
	// ----------------------------------------
	logic [7:0]      nxt_byte [NSTR];
	logic [NSTR-1:0] nxt_en;
	logic [7:0]      tx_sh_r  [NSTR];
	logic [NSTR-1:0] tx_r;
	logic [NSTR-1:0] en_r;
	logic [NSTR-1:0] tx_oe_r;

	always_comb begin
		for (int s = 0; s < NSTR; s++) begin
			logic [MIW-1:0] i;
			logic [7:0]     lo;
			logic [MIW-1:0] src;
			i   = {2'(s), ch_nxt};
			lo  = cml_mem[i];
			src = {lo[SRC_STR_HI:SRC_STR_LO],
				lo[SRC_CH_HI:SRC_CH_LO]};
			if (pe) begin
				nxt_byte[s] = lo;
				nxt_en[s]   = 1'b1;
			end else begin
				nxt_byte[s] = cmh_mem[i][1] ? lo
					: dm_mem[src];
				nxt_en[s]   = cmh_mem[i][0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < NSTR; s++) begin
				tx_sh_r[s] <= 8'h00;
			end
			tx_r <= '0;
			en_r <= '0;
		end else if (ch_end) begin
			for (int s = 0; s < NSTR; s++) begin
				tx_sh_r[s] <= nxt_byte[s];
				tx_r[s]    <= nxt_byte[s][7];
			end
			en_r <= nxt_en;
		end else if (ser_rise && cnt_r[0]) begin
			for (int s = 0; s < NSTR; s++) begin
				tx_sh_r[s] <= {tx_sh_r[s][6:0], 1'b0};
				tx_r[s]    <= tx_sh_r[s][6];
			end
		end
	end

	// master drive gate overrides everything
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_oe_r <= '0;
		end else begin
			tx_oe_r <= ode_s ? en_r : '0;
		end
	end

	assign tx_o    = tx_r;
	assign tx_oe_o = tx_oe_r;
endmodule

// >>> verif/tsw_switch_ctrl_monitor.sv
// pin-level assertions for the time slot switch control block
// bound into tsw_switch_ctrl; needs only its top-level ports
module tsw_switch_ctrl_monitor
	import tsw_pkg::*;
#(
	parameter int NSTR = STREAMS
) (
	// clock and reset
	input  wire logic            core_clk_i,
	input  wire logic            rst_n_i,
	// serial side
	input  wire logic            ode_i,
	input  wire logic [NSTR-1:0] tx_oe_o,
	// processor port
	input  wire logic            cs_n_i,
	input  wire logic            rd_i,
	input  wire logic [5:0]      addr_i,
	input  wire logic [7:0]      data_i,
	input  wire logic [7:0]      data_o,
	input  wire logic            data_oe_o,
	input  wire logic            ack_n_o,
	input  wire logic            ack_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] ctrl_r;
	logic       mem_rd;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// shadow of the control register from observed writes
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ctrl_r <= CTRL_RST;
		else if ($rose(ack_oe_o) && !rd_i && !addr_i[CTRL_SEL_BIT])
			ctrl_r <= data_i & CTRL_MASK;
	end
	assign mem_rd = addr_i[CTRL_SEL_BIT] && !ctrl_r[SM_BIT];

	ack_rise_a: assert property (
		$fell(cs_n_i) |-> ##[2:4] (ack_oe_o && !ack_n_o))
		else $error("ack missing after select");
	ack_hold_a: assert property (
		$rose(cs_n_i) |-> ack_oe_o [*2])
		else $error("ack dropped too early");
	ack_drop_a: assert property (
		$rose(cs_n_i) |-> ##[2:4] (!ack_oe_o && ack_n_o && !data_oe_o))
		else $error("bus not released");
	read_drive_a: assert property (
		$rose(ack_oe_o) |-> data_oe_o == rd_i)
		else $error("data drive mismatch");
	ctrl_back_a: assert property (
		$rose(data_oe_o) && !addr_i[CTRL_SEL_BIT] |-> data_o == ctrl_r)
		else $error("control readback wrong");
	high_zero_a: assert property (
		$rose(data_oe_o) && mem_rd && ctrl_r[MS_HI:MS_LO] == MS_HIGH
		|-> data_o[7:3] == 5'h00)
		else $error("high bits not zero");
	null_read_a: assert property (
		$rose(data_oe_o) && mem_rd && ctrl_r[MS_HI:MS_LO] == 2'h0
		|-> data_o == 8'h00)
		else $error("null select read not zero");
	read_hold_a: assert property (
		data_oe_o && $past(data_oe_o) |-> $stable(data_o))
		else $error("read data moved");
	ode_off_a: assert property (
		(!ode_i) [*5] |-> tx_oe_o == '0)
		else $error("output driven with drive low");

	cover property ($rose(data_oe_o) && ctrl_r[SM_BIT]);
	cover property (ctrl_r[PE_BIT] && tx_oe_o != '0);
	cover property ($rose(ack_oe_o) && !rd_i && !addr_i[CTRL_SEL_BIT]);
endmodule

bind tsw_switch_ctrl tsw_switch_ctrl_monitor #(.NSTR(NSTR)) u_mon (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ode_i(ode_i),
	.tx_oe_o(tx_oe_o), .cs_n_i(cs_n_i), .rd_i(rd_i), .addr_i(addr_i),
	.data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
	.ack_n_o(ack_n_o), .ack_oe_o(ack_oe_o)
);

// >>> verif/tsw_cpu_model.sv
// processor model on the parallel port of the switch control block
// drives on falling edges; waits for ack under a bounded count
module tsw_cpu_model (
	input  wire logic       clk_i,
	input  wire logic       ack_oe_i,
	input  wire logic [7:0] rdata_i,
	output logic            cs_n_o,
	output logic            rd_o,
	output logic [5:0]      addr_o,
	output logic [7:0]      wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n_o = 1'b1;
		rd_o = 1'b1;
		addr_o = 6'h00;
		wdata_o = 8'h00;
	end

	task automatic acc(input logic r, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		int n;
		@(negedge clk_i);
		rd_o = r;
		addr_o = a;
		wdata_o = r ? ~wdata_o : d;
		repeat (3) @(negedge clk_i);
		cs_n_o = 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_oe_i !== 1'b1 && n < 20);
		q = rdata_i;
		ok = (n < 20);
		cs_n_o = 1'b1;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_oe_i !== 1'b0 && n < 20);
	endtask
endmodule

// >>> verif/tsw_switch_ctrl_bench.sv
// self-checking bench of the switch control block
// bench makes the serial clock, frame pulse and receive streams
module tsw_switch_ctrl_bench import tsw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       ser_clk = 1'b0;
	logic       frame_n = 1'b0;
	logic       master_output_drive_input = 1'b0;
	logic [3:0] rx = 4'h0;
	logic [3:0] tx, tx_oe, en4;
	logic       cs_n, rd, data_oe, ack_n, ack_oe;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, b;
	logic [7:0] sh [4];
	logic [7:0] cap [4];
	int         cnt = 0;
	int         k = 0;
	int         miscompares = 0;
	int         num_checks = 0;
	event       frm_ev, ch_ev;

	always #4 core_clk = ~core_clk;

	tsw_switch_ctrl u_dut (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .ser_clk_i(ser_clk),
		.frame_n_i(frame_n), .rx_i(rx), .ode_i(master_output_drive_input), .tx_o(tx),
		.tx_oe_o(tx_oe), .cs_n_i(cs_n), .rd_i(rd), .addr_i(addr),
		.data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
		.ack_n_o(ack_n), .ack_oe_o(ack_oe)
	);
	tsw_cpu_model u_cpu (
		// an undriven data bus shows the inverse of the last value
		.clk_i(core_clk), .ack_oe_i(ack_oe),
		.rdata_i(data_oe ? rdata : ~rdata),
		.cs_n_o(cs_n), .rd_o(rd), .addr_o(addr), .wdata_o(wdata)
	);

	function automatic logic [7:0] rxb(int s, int c);
		return {1'b1, s[1:0], c[4:0]};
	endfunction

	// ----------------------------------------
	// serial side: 240 ns serial clock, two per bit, capture of channel 4
	// ----------------------------------------
	initial forever begin
		repeat (15) @(negedge core_clk);
		ser_clk = 1'b1;
		repeat (15) @(negedge core_clk);
		ser_clk = 1'b0;
		for (int s = 0; s < 4; s++) begin
			if (cnt % 2 == 0)
				sh[s] = {sh[s][6:0], tx[s]};
			if (cnt == 72)
				en4[s] = tx_oe[s];
			if (cnt == 78)
				cap[s] = sh[s];
		end
		if (cnt == 78)
			->ch_ev;
		cnt = (cnt + 1) % EDGES_PER_FRM;
		frame_n = (cnt != 0);
		if (cnt == 0)
			->frm_ev;
		// each bit is taken at the rise that closes its two clocks
		k = (cnt + EDGES_PER_FRM - 1) % EDGES_PER_FRM;
		for (int s = 0; s < 4; s++) begin
			b = rxb(s, k / 16);
			rx[s] = b[7 - k % 16 / 2];
		end
	end

	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic acc(logic r, logic [5:0] a, logic [7:0] d,
		output logic [7:0] q);
		logic ok;
		u_cpu.acc(r, a, d, q, ok);
		chk("ack", {7'h00, ok}, 8'h01);
	endtask

	task automatic wr(logic [5:0] a, logic [7:0] d);
		logic [7:0] q;
		acc(1'b0, a, d, q);
	endtask

	task automatic rdc(string what, logic [5:0] a, logic [7:0] e);
		logic [7:0] q;
		acc(1'b1, a, 8'h00, q);
		chk(what, q, e);
	endtask

	task automatic sel(logic [7:0] hi, logic [1:0] ms, logic [1:0] s);
		wr(6'h00, hi | {3'h0, ms, 1'b0, s});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ctrl();
		rdc("ctrl reset", 6'h00, CTRL_RST);
		wr(6'h1c, 8'hff);
		rdc("ctrl mask", 6'h04, 8'hff & CTRL_MASK);
		wr(6'h00, 8'h00);
		$display("test ctrl done");
	endtask

	task automatic t_init();
		for (int i = 0; i < 8; i++) begin
			sel(8'h00, i[0] ? MS_LOW : MS_HIGH, i[2:1]);
			for (int c = 0; c < 32; c++)
				wr({1'b1, c[4:0]}, 8'h00);
		end
		$display("test init done");
	endtask

	task automatic t_mem();
		@(frm_ev);
		@(frm_ev);
		sel(8'h00, MS_DATA, 2'h2);
		rdc("data mem", 6'h29, rxb(2, 9));
		wr(6'h29, 8'h00);
		rdc("data ro", 6'h29, rxb(2, 9));
		sel(8'h00, 2'h0, 2'h2);
		rdc("null sel", 6'h29, 8'h00);
		sel(8'h80, MS_HIGH, 2'h2);
		wr(6'h27, 8'h5a);
		rdc("split rd", 6'h27, rxb(2, 7));
		sel(8'h00, MS_LOW, 2'h2);
		rdc("split wr", 6'h27, 8'h5a);
		sel(8'h00, MS_LOW, 2'h1);
		rdc("stream sel", 6'h27, 8'h00);
		sel(8'h00, MS_HIGH, 2'h2);
		wr(6'h27, 8'hfd);
		rdc("high zeros", 6'h27, 8'h05);
		$display("test mem done");
	endtask

	task automatic t_out();
		sel(8'h00, MS_LOW, 2'h0);
		wr(6'h24, 8'ha7);
		sel(8'h00, MS_HIGH, 2'h0);
		wr(6'h24, 8'h05);
		sel(8'h00, MS_LOW, 2'h1);
		wr(6'h24, 8'h49);
		sel(8'h00, MS_HIGH, 2'h1);
		wr(6'h24, 8'h01);
		sel(8'h00, MS_LOW, 2'h2);
		wr(6'h24, 8'h3c);
		sel(8'h00, MS_HIGH, 2'h2);
		wr(6'h24, 8'h04);
		@(negedge core_clk);
		master_output_drive_input = 1'b1;
		@(frm_ev);
		@(ch_ev);
		chk("tx s0", cap[0], 8'ha7);
		chk("oe s0", {7'h00, en4[0]}, 8'h01);
		chk("tx s1", cap[1], rxb(2, 9));
		chk("oe s2", {7'h00, en4[2]}, 8'h00);
		sel(8'h40, 2'h0, 2'h0);
		@(frm_ev);
		@(ch_ev);
		chk("pe s1", cap[1], 8'h49);
		chk("pe oe", {4'h0, en4}, 8'h0f);
		@(negedge core_clk);
		master_output_drive_input = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("ode off", {4'h0, tx_oe}, 8'h00);
		$display("test out done");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		t_ctrl();
		t_init();
		t_mem();
		t_out();
		end_of_test();
	end

	initial begin
		repeat (80000) @(posedge core_clk);
		miscompares++;
		$display("BAD watchdog expected done seen hang");
		end_of_test();
	end
endmodule
